/* File: power_image_pkg.sv */
package power_image_pkg;

  // register map
  localparam logic [7:0] POLARITY_CONFIG_ADDR       = 8'h1d;
  localparam logic [7:0] CONTROL_ACTIVE_IMAGE_ADDR  = 8'h21;
  localparam logic [7:0] POLARITY_ACTIVE_IMAGE_ADDR = 8'h23;
  localparam logic [7:0] CONTROL_PRIOR_IMAGE_ADDR   = 8'h24;
  localparam logic [7:0] UNMAPPED_READ_VALUE        = 8'h00;

  // reset values of the images
  localparam logic [7:0] POLARITY_IMAGE_RESET = 8'h00;
  localparam logic [7:0] CONTROL_IMAGE_RESET  = 8'h00;

  // field positions in the control byte
  localparam int RATE_MSB      = 7;
  localparam int RATE_LSB      = 6;
  localparam int SLEEP_BIT     = 5;
  localparam int SINGLE_BIT    = 4;
  localparam int ALERT_PIN_BIT = 3;
  localparam int CC_ALERT_BIT  = 2;
  localparam int OVERFLOW_ALERT_EN_BIT = 1;
  localparam int OVF_FLAG_BIT  = 0;

  // field positions in the polarity byte
  localparam int SENSE_MSB = 7;
  localparam int SENSE_LSB = 4;
  localparam int BUS_MSB   = 3;
  localparam int BUS_LSB   = 0;

  // rate codes
  localparam logic [1:0] RATE_1024 = 2'h0;
  localparam logic [1:0] RATE_256  = 2'h1;
  localparam logic [1:0] RATE_64   = 2'h2;
  localparam logic [1:0] RATE_8    = 2'h3;

  // timing
  localparam int CLOCK_HZ         = 10_000_000;
  localparam int CLOCK_PERIOD_NS  = 100;
  localparam int VALID_TIME_NS    = 1_000_000;
  localparam int VALID_CYCLES     = (VALID_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int ALERT_TIME_NS    = 5_000;
  localparam int ALERT_CYCLES     = (ALERT_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RATE_SPS_1024    = 1024;
  localparam int RATE_SPS_256     = 256;
  localparam int RATE_SPS_64      = 64;
  localparam int RATE_SPS_8       = 8;
  localparam int RATE_CYCLES_1024 = CLOCK_HZ / RATE_SPS_1024;
  localparam int RATE_CYCLES_256  = CLOCK_HZ / RATE_SPS_256;
  localparam int RATE_CYCLES_64   = CLOCK_HZ / RATE_SPS_64;
  localparam int RATE_CYCLES_8    = CLOCK_HZ / RATE_SPS_8;

  // control settings byte
  typedef struct packed {
    logic [1:0] rate;
    logic       sleep;
    logic       single_shot_sel;
    logic       alert_pin_en;
    logic       cycle_done_alert_en;
    logic       overflow_alert_en;
    logic       overflow_flag;
  } control_t;

  // polarity byte: index 3 is channel 1
  typedef struct packed {
    logic [3:0] sense_bipolar_sel;
    logic [3:0] bus_bipolar_sel;
  } polarity_t;

  // register port request
  typedef struct packed {
    logic       rdEn;
    logic       wrEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } reg_req_t;

  // validity of the images
  typedef enum logic [1:0] {
    WAIT_COMMIT,
    SETTLING,
    IMAGES_VALID
  } valid_state_t;

endpackage

/* File: hold_timer.sv */
// holds busy for CYCLES clocks after start; a new start restarts the count
module hold_timer #(
  parameter int unsigned CYCLES = 50
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic start,
  output logic      busy,
  output logic      expired
);

  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES);
  localparam logic [W-1:0] ONE  = W'(1);

  logic [W-1:0] count_q;

  generate
    if (CYCLES < 1) begin : bad_cycles
      $error("hold_timer needs at least one cycle");
    end
  endgenerate

  // down counter
  always_ff @(posedge clock) begin
    if (!rstn) begin
      count_q <= '0;
    end else if (start) begin
      count_q <= LOAD;
    end else if (count_q != '0) begin
      count_q <= count_q - ONE;
    end
  end

  assign busy    = (count_q != '0);
  assign expired = (count_q == ONE) && !start; // last busy cycle

endmodule // hold_timer

/* File: config_active_and_prior_images.sv */
module config_active_and_prior_images #(
  parameter int unsigned VALID_CYC     = power_image_pkg::VALID_CYCLES,
  parameter int unsigned ALERT_CYC     = power_image_pkg::ALERT_CYCLES,
  parameter int unsigned RATE_CYC_1024 = power_image_pkg::RATE_CYCLES_1024,
  parameter int unsigned RATE_CYC_256  = power_image_pkg::RATE_CYCLES_256,
  parameter int unsigned RATE_CYC_64   = power_image_pkg::RATE_CYCLES_64,
  parameter int unsigned RATE_CYC_8    = power_image_pkg::RATE_CYCLES_8
) (
  input  wire logic                      clock,
  input  wire logic                      rstn,
  input  wire power_image_pkg::reg_req_t regReq,
  output logic [7:0]                     regRdData,
  output logic                           regWrRefused,
  input  wire power_image_pkg::control_t controlConfig,
  input  wire power_image_pkg::polarity_t polarityConfig,
  input  wire logic                      commit,
  input  wire logic                      cycleDone,
  input  wire logic                      overflowEvent,
  output power_image_pkg::control_t      controlActive,
  output power_image_pkg::polarity_t     polarityActive,
  output logic [3:0]                     senseSigned,
  output logic [3:0]                     busSigned,
  output logic                           convEnable,
  output logic                           sampleTick,
  output logic                           imagesValid,
  output logic                           alertO,
  output logic                           alertOe
);
  import power_image_pkg::*;

  localparam int CW = 21;

  generate
    if (RATE_CYC_8 >= (1 << CW) || RATE_CYC_1024 < 2 || VALID_CYC < 1 || ALERT_CYC < 1) begin : bad_params
      $error("rate, valid or alert counts out of range");
    end
  endgenerate

  control_t     ctrlActive_q;
  control_t     ctrlPrior_q;
  polarity_t    polActive_q;
  logic         ovfSeen_q;
  logic [7:0]   rdData_q;
  logic         wrRefused_q;
  logic [CW-1:0] rateCount_q;
  logic [CW-1:0] rateLimit;
  logic         singleDone_q;
  logic         tick;
  logic         settleBusy;
  logic         settleDone;
  logic         ccAlertBusy;
  logic         imageHit;
  logic         ovfFlagNow;
  valid_state_t validState_q;

  // active control and polarity copies, loaded only by a commit
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrlActive_q <= control_t'(CONTROL_IMAGE_RESET);
      polActive_q  <= polarity_t'(POLARITY_IMAGE_RESET);
    end else if (commit) begin
      ctrlActive_q <= controlConfig;
      polActive_q  <= polarityConfig;
    end
  end

  // live overflow flag: set by an event, cleared by commit, set wins
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ovfSeen_q <= 1'b0;
    end else if (overflowEvent) begin
      ovfSeen_q <= 1'b1;
    end else if (commit) begin
      ovfSeen_q <= 1'b0;
    end
  end

  assign ovfFlagNow = ctrlActive_q.overflow_flag | ovfSeen_q;

  // prior image takes the settings in force until this commit
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrlPrior_q <= control_t'(CONTROL_IMAGE_RESET);
    end else if (commit) begin
      ctrlPrior_q               <= ctrlActive_q;
      ctrlPrior_q.overflow_flag <= ovfFlagNow;
    end
  end

  // validity window after each commit
  hold_timer #(
    .CYCLES(VALID_CYC)
  ) settleTimer (
    .clock  (clock),
    .rstn   (rstn),
    .start  (commit),
    .busy   (settleBusy),
    .expired(settleDone)
  );

  // validity state
  always_ff @(posedge clock) begin
    if (!rstn) begin
      validState_q <= WAIT_COMMIT;
    end else if (commit) begin
      validState_q <= SETTLING;
    end else begin
      unique case (validState_q)
        WAIT_COMMIT:  validState_q <= WAIT_COMMIT;
        SETTLING:     validState_q <= settleDone ? IMAGES_VALID : SETTLING;
        IMAGES_VALID: validState_q <= IMAGES_VALID;
      endcase
    end
  end

  assign imagesValid = (validState_q == IMAGES_VALID);

  // sample period from the active rate code
  always_comb begin
    unique case (ctrlActive_q.rate)
      RATE_1024: rateLimit = CW'(RATE_CYC_1024 - 1);
      RATE_256:  rateLimit = CW'(RATE_CYC_256 - 1);
      RATE_64:   rateLimit = CW'(RATE_CYC_64 - 1);
      RATE_8:    rateLimit = CW'(RATE_CYC_8 - 1);
    endcase
  end

  // sample divider, held while asleep and restarted by commit
  always_ff @(posedge clock) begin
    if (!rstn || commit || ctrlActive_q.sleep) begin
      rateCount_q <= '0;
    end else if (rateCount_q >= rateLimit) begin
      rateCount_q <= '0;
    end else begin
      rateCount_q <= rateCount_q + CW'(1);
    end
  end

  // single-shot stops after the first completed cycle
  always_ff @(posedge clock) begin
    if (!rstn || commit) begin
      singleDone_q <= 1'b0;
    end else if (cycleDone && ctrlActive_q.single_shot_sel) begin
      singleDone_q <= 1'b1;
    end
  end

  assign convEnable = !ctrlActive_q.sleep && !(ctrlActive_q.single_shot_sel && singleDone_q);
  assign tick       = convEnable && !commit && (rateCount_q >= rateLimit);
  assign sampleTick = tick;

  // cycle-done alert stretch
  hold_timer #(
    .CYCLES(ALERT_CYC)
  ) alertTimer (
    .clock  (clock),
    .rstn   (rstn),
    .start  (cycleDone && ctrlActive_q.cycle_done_alert_en),
    .busy   (ccAlertBusy),
    .expired()
  );

  // open-drain alert, low while driven
  assign alertO  = 1'b0;
  assign alertOe = ctrlActive_q.alert_pin_en &&
                   (ccAlertBusy || (ctrlActive_q.overflow_alert_en && ovfFlagNow));

  // register read port, one cycle latency
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdData_q <= UNMAPPED_READ_VALUE;
    end else if (regReq.rdEn) begin
      unique case (regReq.addr)
        POLARITY_ACTIVE_IMAGE_ADDR: rdData_q <= polActive_q;
        CONTROL_PRIOR_IMAGE_ADDR:   rdData_q <= ctrlPrior_q;
        default:                    rdData_q <= UNMAPPED_READ_VALUE;
      endcase
    end
  end

  assign imageHit = (regReq.addr == POLARITY_ACTIVE_IMAGE_ADDR) ||
                    (regReq.addr == CONTROL_PRIOR_IMAGE_ADDR);

  // writes to the polarity and prior images are dropped and flagged for one cycle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wrRefused_q <= 1'b0;
    end else begin
      wrRefused_q <= regReq.wrEn && imageHit;
    end
  end

  assign regRdData      = rdData_q;
  assign regWrRefused   = wrRefused_q;
  assign controlActive  = ctrlActive_q;
  assign polarityActive = polActive_q;
  assign senseSigned    = polActive_q.sense_bipolar_sel;
  assign busSigned      = polActive_q.bus_bipolar_sel;

  // polarity image moves only on commit
  pol_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    !commit |=> $stable(polActive_q))
    else $error("polarity image changed without commit");

  // polarity image takes the written value on commit
  pol_load_a: assert property (@(posedge clock) disable iff (!rstn)
    commit |=> polActive_q == $past(polarityConfig))
    else $error("polarity image not loaded by commit");

  // prior image equals the old active settings
  prior_copy_a: assert property (@(posedge clock) disable iff (!rstn)
    commit |=> ctrlPrior_q[7:1] == $past(ctrlActive_q[7:1]) && ctrlActive_q == $past(controlConfig))
    else $error("prior image not copied from active settings");

  // images invalid right after a commit
  settle_gap_a: assert property (@(posedge clock) disable iff (!rstn)
    commit |=> !imagesValid [*8])
    else $error("images valid too soon after commit");

  // validity only at the end of the settle time
  valid_rise_a: assert property (@(posedge clock) disable iff (!rstn)
    $rose(imagesValid) |-> $past(settleDone) && !settleBusy)
    else $error("images valid before settle time elapsed");

  // cycle-done alert is held
  cc_alert_a: assert property (@(posedge clock) disable iff (!rstn)
    cycleDone && ctrlActive_q.cycle_done_alert_en && ctrlActive_q.alert_pin_en && !commit
      |=> alertOe [*8])
    else $error("cycle-done alert not held");

  // no sampling while asleep
  sleep_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
    ctrlActive_q.sleep |-> !sampleTick)
    else $error("sample tick while asleep");

  // ticks at least nine cycles apart at every rate
  tick_space_a: assert property (@(posedge clock) disable iff (!rstn)
    sampleTick |=> !sampleTick [*8])
    else $error("sample ticks too close");

  // single-shot stops after one cycle
  single_stop_a: assert property (@(posedge clock) disable iff (!rstn)
    ctrlActive_q.single_shot_sel && singleDone_q |-> !sampleTick && !convEnable)
    else $error("single-shot kept converting");

  // writes leave images unchanged
  write_ignore_a: assert property (@(posedge clock) disable iff (!rstn)
    regReq.wrEn && !commit |=> $stable(polActive_q) && $stable(ctrlPrior_q) && regWrRefused == $past(imageHit))
    else $error("image changed by a host write");

  // prior image read returns its contents
  prior_read_a: assert property (@(posedge clock) disable iff (!rstn)
    regReq.rdEn && regReq.addr == CONTROL_PRIOR_IMAGE_ADDR |=> regRdData == $past(ctrlPrior_q))
    else $error("prior image read wrong");

  // reset clears both images and the validity
  reset_zero_a: assert property (@(posedge clock)
    !rstn |=> polActive_q == polarity_t'(POLARITY_IMAGE_RESET) && ctrlPrior_q == control_t'(CONTROL_IMAGE_RESET) && !imagesValid)
    else $error("images not cleared by reset");

  // prior image moves only on commit
  prior_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    !commit |=> $stable(ctrlPrior_q))
    else $error("prior image changed without commit");

  // active control copy moves only on commit
  active_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    !commit |=> $stable(ctrlActive_q))
    else $error("active settings changed without commit");

  // polarity image read returns its contents
  pol_read_a: assert property (@(posedge clock) disable iff (!rstn)
    regReq.rdEn && regReq.addr == POLARITY_ACTIVE_IMAGE_ADDR |=> regRdData == $past(polActive_q))
    else $error("polarity image read wrong");

  // sense selections sit in the upper nibble
  sense_map_a: assert property (@(posedge clock) disable iff (!rstn)
    senseSigned == polActive_q[SENSE_MSB:SENSE_LSB])
    else $error("sense polarity mapped wrong");

  // bus selections sit in the lower nibble
  bus_map_a: assert property (@(posedge clock) disable iff (!rstn)
    busSigned == polActive_q[BUS_MSB:BUS_LSB])
    else $error("bus polarity mapped wrong");

  // an overflow is remembered even when a commit clears it
  ovf_set_a: assert property (@(posedge clock) disable iff (!rstn)
    overflowEvent |=> ovfSeen_q)
    else $error("overflow event lost");

  // a remembered overflow lands in the prior image
  prior_ovf_a: assert property (@(posedge clock) disable iff (!rstn)
    commit && ovfSeen_q |=> ctrlPrior_q.overflow_flag)
    else $error("overflow not recorded in prior image");

  // single-shot stops right after its cycle completes
  single_done_a: assert property (@(posedge clock) disable iff (!rstn)
    cycleDone && ctrlActive_q.single_shot_sel && !commit |=> !convEnable)
    else $error("single-shot not stopped");

  // no alert while the pin function is off
  pin_off_a: assert property (@(posedge clock) disable iff (!rstn)
    !ctrlActive_q.alert_pin_en |-> !alertOe)
    else $error("alert driven while pin disabled");

endmodule // config_active_and_prior_images

/* File: reg_host.sv */
// host side of the register port: one strobe per access, answers taken a cycle later
module reg_host (
  input  wire logic                       clock,
  input  wire logic [7:0]                 regRdData,
  input  wire logic                       regWrRefused,
  input  wire logic                       imagesValid,
  output power_image_pkg::reg_req_t       regReq
);
  timeunit 1ns;
  timeprecision 1ns;
  import power_image_pkg::*;

  // idle request at time zero
  initial regReq = '0;

  // read: strobe for one cycle, data is registered at the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    regReq <= '{rdEn: 1'b1, wrEn: 1'b0, addr: a, wrData: 8'h00};
    @(negedge clock);
    regReq.rdEn <= 1'b0;
    d = regRdData;
  endtask

  // write: strobe for one cycle, refusal pulse is seen the cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic refused);
    @(negedge clock);
    regReq <= '{rdEn: 1'b0, wrEn: 1'b1, addr: a, wrData: v};
    @(negedge clock);
    regReq.wrEn <= 1'b0;
    refused = regWrRefused;
  endtask

  // images are trusted only after the settle time has passed
  task automatic wait_valid(input int lim, output int n);
    n = 0;
    while (imagesValid !== 1'b1 && n < lim) begin
      @(negedge clock);
      n++;
    end
  endtask
endmodule // reg_host

/* File: config_active_and_prior_images_tb.sv */
module config_active_and_prior_images_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import power_image_pkg::*;

  localparam int VCYC = 20;
  localparam int ACYC = 50;

  logic       clock;
  logic       rstn;
  reg_req_t   regReq;
  logic [7:0] regRdData;
  logic       regWrRefused;
  control_t   controlConfig;
  polarity_t  polarityConfig;
  logic       commit;
  logic       cycleDone;
  logic       overflowEvent;
  control_t   controlActive;
  polarity_t  polarityActive;
  logic [3:0] senseSigned;
  logic [3:0] busSigned;
  logic       convEnable;
  logic       sampleTick;
  logic       imagesValid;
  logic       alertO;
  logic       alertOe;
  int         errCount;
  int         nTests;

  config_active_and_prior_images #(.VALID_CYC(VCYC), .ALERT_CYC(ACYC), .RATE_CYC_1024(10),
    .RATE_CYC_256(20), .RATE_CYC_64(30), .RATE_CYC_8(40)) dut (
    .clock(clock), .rstn(rstn), .regReq(regReq), .regRdData(regRdData), .regWrRefused(regWrRefused),
    .controlConfig(controlConfig), .polarityConfig(polarityConfig), .commit(commit),
    .cycleDone(cycleDone), .overflowEvent(overflowEvent), .controlActive(controlActive),
    .polarityActive(polarityActive), .senseSigned(senseSigned), .busSigned(busSigned),
    .convEnable(convEnable), .sampleTick(sampleTick), .imagesValid(imagesValid),
    .alertO(alertO), .alertOe(alertOe));

  reg_host host (.clock(clock), .regRdData(regRdData), .regWrRefused(regWrRefused),
    .imagesValid(imagesValid), .regReq(regReq));

  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errCount++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one commit pulse, then one cycle for the images to load
  task automatic do_commit(input control_t cfg);
    @(negedge clock);
    controlConfig = cfg;
    commit = 1'b1;
    @(negedge clock);
    commit = 1'b0;
    @(negedge clock);
  endtask

  // one conversion-cycle-done pulse
  task automatic done_pulse();
    @(negedge clock);
    cycleDone = 1'b1;
    @(negedge clock);
    cycleDone = 1'b0;
  endtask

  // cycles from one sample tick to the next
  task automatic tick_gap(output int n);
    int w;
    w = 0;
    while (sampleTick !== 1'b1 && w < 100) begin
      @(negedge clock);
      w++;
    end
    @(negedge clock);
    n = 1;
    while (sampleTick !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
  endtask

  // number of ticks seen over a span of cycles
  task automatic count_ticks(output int n);
    n = 0;
    repeat (100) begin
      @(negedge clock);
      if (sampleTick === 1'b1) n++;
    end
  endtask

  // watchdog against a hang
  initial begin
    #5_000_000;
    errCount++;
    report_and_stop();
  end

  // test sequence
  initial begin
    logic [7:0] d;
    logic       r;
    int         n;
    control_t   prev;
    control_t   cfg;
    errCount = 0;
    nTests = 0;
    rstn = 1'b0;
    controlConfig = '0;
    polarityConfig = '0;
    commit = 1'b0;
    cycleDone = 1'b0;
    overflowEvent = 1'b0;
    repeat (6) @(negedge clock);
    rstn = 1'b1;
    host.rd(POLARITY_ACTIVE_IMAGE_ADDR, d);
    check(d, 8'h00);
    host.rd(CONTROL_PRIOR_IMAGE_ADDR, d);
    check(d, 8'h00);
    check(imagesValid, 1'b0);
    check(alertOe, 1'b0);
    $display("reset test done");
    // written polarity stays inactive until a commit
    polarityConfig = 8'ha5;
    repeat (3) @(negedge clock);
    check(polarityActive, 8'h00);
    host.rd(POLARITY_ACTIVE_IMAGE_ADDR, d);
    check(d, 8'h00);
    do_commit(8'h00);
    check(imagesValid, 1'b0);
    check(polarityActive, 8'ha5);
    check(senseSigned, 4'ha);
    check(busSigned, 4'h5);
    host.wait_valid(100, n);
    check(n >= VCYC - 3 && n <= VCYC, 1'b1);
    host.rd(POLARITY_ACTIVE_IMAGE_ADDR, d);
    check(d, 8'ha5);
    $display("polarity test done");
    // writes to the polarity and prior images are refused and change nothing
    host.wr(POLARITY_ACTIVE_IMAGE_ADDR, 8'h5a, r);
    check(r, 1'b1);
    host.wr(CONTROL_PRIOR_IMAGE_ADDR, 8'hff, r);
    check(r, 1'b1);
    host.rd(POLARITY_ACTIVE_IMAGE_ADDR, d);
    check(d, 8'ha5);
    host.rd(CONTROL_PRIOR_IMAGE_ADDR, d);
    check(d, 8'h00);
    host.wr(8'h40, 8'h33, r);
    check(r, 1'b0);
    host.rd(8'h40, d);
    check(d, UNMAPPED_READ_VALUE);
    $display("write refusal test done");
    // every rate code: prior image keeps the previous settings, tick period follows the code
    prev = 8'h00;
    for (int i = 0; i < 4; i++) begin
      cfg = {i[1:0], 6'h00};
      do_commit(cfg);
      check(controlActive, cfg);
      host.wait_valid(100, n);
      host.rd(CONTROL_PRIOR_IMAGE_ADDR, d);
      check(d, prev);
      tick_gap(n);
      check(n, 10 * (i + 1));
      prev = cfg;
    end
    $display("rate test done");
    // an overflow before the commit is recorded in the prior image
    @(negedge clock);
    overflowEvent = 1'b1;
    @(negedge clock);
    overflowEvent = 1'b0;
    do_commit(8'h0c);
    host.wait_valid(100, n);
    host.rd(CONTROL_PRIOR_IMAGE_ADDR, d);
    check(d, 8'hc1);
    // cycle-done alert lasts the set number of cycles
    done_pulse();
    n = 0;
    while (alertOe !== 1'b1 && n < 3) begin
      @(negedge clock);
      n++;
    end
    n = 0;
    while (alertOe === 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    check(n, ACYC);
    check(alertO, 1'b0);
    do_commit(8'h08);
    host.wait_valid(100, n);
    host.rd(CONTROL_PRIOR_IMAGE_ADDR, d);
    check(d, 8'h0c);
    done_pulse();
    n = 0;
    repeat (10) begin
      @(negedge clock);
      if (alertOe === 1'b1) n++;
    end
    check(n, 0);
    $display("alert test done");
    // overflow alert holds the pin while enabled, prior image records the overflow
    do_commit(8'h0a);
    check(alertOe, 1'b0);
    @(negedge clock);
    overflowEvent = 1'b1;
    @(negedge clock);
    overflowEvent = 1'b0;
    check(alertOe, 1'b1);
    do_commit(8'h20);
    check(alertOe, 1'b0);
    host.wait_valid(100, n);
    host.rd(CONTROL_PRIOR_IMAGE_ADDR, d);
    check(d, 8'h0b);
    $display("overflow alert test done");
    // sleep stops conversions
    do_commit(8'h20);
    check(convEnable, 1'b0);
    count_ticks(n);
    check(n, 0);
    // single shot stops after the first completed cycle
    do_commit(8'h10);
    check(convEnable, 1'b1);
    tick_gap(n);
    check(n, 10);
    done_pulse();
    count_ticks(n);
    check(n, 0);
    check(convEnable, 1'b0);
    $display("mode test done");
    // a reset in mid-run clears both images and the validity
    @(negedge clock);
    rstn = 1'b0;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    check(imagesValid, 1'b0);
    check(polarityActive, 8'h00);
    host.rd(POLARITY_ACTIVE_IMAGE_ADDR, d);
    check(d, 8'h00);
    host.rd(CONTROL_PRIOR_IMAGE_ADDR, d);
    check(d, 8'h00);
    $display("second reset test done");
    report_and_stop();
  end
endmodule // config_active_and_prior_images_tb
